/* common/slt_pkg.sv */
// Package for the staircase light timer: timing constants, modes, state.
// Assumes a single 250 MHz clock and a synchronous active-low reset.
`default_nettype none
package slt_pkg;
    // Clock rate in kHz (250 MHz)
    localparam longint CLK_KHZ = 250000;
    // Hold time bounds and warning time, in seconds
    localparam int HOLD_MIN_S = 30;
    localparam int HOLD_MAX_S = 600;
    localparam int WARN_S = 30;
    // Cycles per second of the time base
    localparam longint SEC_CYC = CLK_KHZ * 1000;
    localparam int SEC_W = 28;
    localparam int TIME_W = 10;
    // Reset values
    localparam logic [SEC_W-1:0] SEC_RST = 28'h0000000;
    localparam logic [TIME_W-1:0] TIME_RST = 10'h000;

    // Lamp drive levels
    typedef enum logic [1:0] {
        SLT_LAMP_OFF = 2'b00,
        SLT_LAMP_HALF = 2'b01,
        SLT_LAMP_FULL = 2'b10
    } slt_lamp_t;

    // Controller states
    typedef enum logic [1:0] {
        SLT_IDLE = 2'b00,
        SLT_HOLD = 2'b01,
        SLT_WARN = 2'b10,
        SLT_LOCK = 2'b11
    } slt_state_t;

    // Whole state of the controller
    typedef struct packed {
        slt_state_t state;
        logic [TIME_W-1:0] secs;
        logic btn_prev;
        slt_lamp_t lamp;
    } slt_ctl_t;

    // Synchroniser and time base state
    typedef struct packed {
        logic meta;
        logic sync;
        logic [SEC_W-1:0] cnt;
        logic tick;
    } slt_sync_t;
endpackage
`default_nettype wire

/* rtl/slt_sync.sv */
// Two-flop synchroniser plus one-second tick generator.
// Assumes an asynchronous button level and a free-running MCLK.
`default_nettype none
module slt_sync
    import slt_pkg::*;
#(
    parameter longint SEC_CYCLES = SEC_CYC
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic din,
    output logic dout,
    output logic tick
);
    slt_sync_t q, next_q;

    // Meta flop is read only by the second flop; the tick counter
    // wraps every SEC_CYCLES cycles and pulses tick for one cycle
    always_comb begin
        next_q.meta = din;
        next_q.sync = q.meta;
        next_q.tick = 1'b0;
        next_q.cnt = q.cnt + 28'h0000001;
        if (q.cnt == SEC_W'(SEC_CYCLES - 1)) begin
            next_q.cnt = SEC_RST;
            next_q.tick = 1'b1;
        end
    end

    // State register
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            q <= '{1'b0, 1'b0, SEC_RST, 1'b0};
        end else begin
            q <= next_q;
        end
    end

    assign dout = q.sync;
    assign tick = q.tick;
endmodule
`default_nettype wire

/* rtl/slt_top.sv */
// Staircase light timer with dimmed warning phase and anti-lock.
// Assumes a pushbutton level on BTN (async) and a lamp driver on LAMP.
// Functional notes
// (R1) From idle a button assertion lights the lamp fully and starts hold.
// (R2) Full brightness lasts the selected hold time, 30 s to 10 min.
// (R3) After hold the lamp runs at half brightness for about 30 s.
// (R4) Only after the warning interval ends is the lamp off and idle; an anti-lock shutoff goes dark straight from hold.
// (R5) A press during warning restores full brightness and a new hold.
// (R6) With anti-lock on, a held button cannot keep the lamp on past hold.
// (R7) After an anti-lock shutoff, relighting needs release then press.
// (R8) Anti-lock is a config input; when off a held button retriggers.
`default_nettype none
module slt_top
    import slt_pkg::*;
#(
    parameter longint SEC_CYCLES = SEC_CYC
) (
    input wire logic MCLK,
    input wire logic RST_N,
    input wire logic BTN,
    input wire logic ANTI_LOCK,
    input wire logic [TIME_W-1:0] HOLD_SEC,
    output slt_lamp_t LAMP
);
    import slt_pkg::*;

    logic btn;
    logic tick;
    logic [TIME_W-1:0] hold_lim;
    slt_ctl_t r, next_r;

    // Last hold second reached; shared by the logic and the checks
    function automatic logic hold_done(input logic [TIME_W-1:0] secs,
        input logic [TIME_W-1:0] lim);
        return secs >= lim - 10'h001;
    endfunction

    // Last warning second reached
    function automatic logic warn_done(input logic [TIME_W-1:0] secs);
        return secs >= TIME_W'(WARN_S - 1);
    endfunction

    slt_sync #(.SEC_CYCLES(SEC_CYCLES)) u_sync (
        .clk(MCLK),
        .rst_n(RST_N),
        .din(BTN),
        .dout(btn),
        .tick(tick)
    );

    // Clamp hold setting into the supported range
    always_comb begin
        hold_lim = HOLD_SEC;
        if (HOLD_SEC < TIME_W'(HOLD_MIN_S)) begin
            hold_lim = TIME_W'(HOLD_MIN_S);
        end
        if (HOLD_SEC > TIME_W'(HOLD_MAX_S)) begin
            hold_lim = TIME_W'(HOLD_MAX_S);
        end
    end

    // Next-state logic; seconds counted on the shared tick, so timing
    // is accurate to within one second, traded for a small counter
    always_comb begin
        logic press;
        press = btn & ~r.btn_prev;
        next_r = r;
        next_r.btn_prev = btn;
        unique case (r.state)
            SLT_IDLE: begin
                // (R1) press turns lamp on
                if (press) begin
                    next_r.state = SLT_HOLD;
                    next_r.secs = TIME_RST;
                    next_r.lamp = SLT_LAMP_FULL;
                end
            end
            SLT_HOLD: begin
                // (R8) held button retriggers without anti-lock
                if (btn && !ANTI_LOCK) begin
                    next_r.secs = TIME_RST;
                // (R2) count hold seconds
                end else if (tick) begin
                    if (hold_done(r.secs, hold_lim)) begin
                        next_r.secs = TIME_RST;
                        // (R6) stuck button goes dark
                        if (btn && ANTI_LOCK) begin
                            next_r.state = SLT_LOCK;
                            next_r.lamp = SLT_LAMP_OFF;
                        end else begin
                            // (R3) enter half brightness
                            next_r.state = SLT_WARN;
                            next_r.lamp = SLT_LAMP_HALF;
                        end
                    end else begin
                        next_r.secs = r.secs + 10'h001;
                    end
                end
            end
            SLT_WARN: begin
                // (R5) press restores full
                if (press || (btn && !ANTI_LOCK)) begin
                    next_r.state = SLT_HOLD;
                    next_r.secs = TIME_RST;
                    next_r.lamp = SLT_LAMP_FULL;
                end else if (tick) begin
                    // (R4) off after warning
                    if (warn_done(r.secs)) begin
                        next_r.state = SLT_IDLE;
                        next_r.secs = TIME_RST;
                        next_r.lamp = SLT_LAMP_OFF;
                    end else begin
                        next_r.secs = r.secs + 10'h001;
                    end
                end
            end
            SLT_LOCK: begin
                // (R7) wait for release
                if (!btn) begin
                    next_r.state = SLT_IDLE;
                end
            end
        endcase
    end

    always_ff @(posedge MCLK) begin
        if (!RST_N) begin
            r <= '{SLT_IDLE, TIME_RST, 1'b0, SLT_LAMP_OFF};
        end else begin
            r <= next_r;
        end
    end

    assign LAMP = r.lamp;

    // Assertions; each label line carries the rule it guards
    sequence s_press;
        !btn ##1 btn;
    endsequence

    // Last hold second passing with the button stuck high
    sequence s_stuck_expiry;
        r.state == SLT_HOLD && tick && btn && ANTI_LOCK &&
            hold_done(r.secs, hold_lim);
    endsequence

    // Stuck button finally released while locked
    sequence s_lock_release;
        r.state == SLT_LOCK && !btn;
    endsequence

    // (R1) press from idle
    AST_IDLE_ON: assert property ( // (R1)
        @(posedge MCLK) disable iff (!RST_N)
        (r.state == SLT_IDLE && btn && !r.btn_prev)
        |=> LAMP == SLT_LAMP_FULL)
        else $error("press in idle did not light lamp");
    // (R2) full during hold
    AST_HOLD_FULL: assert property ( // (R2)
        @(posedge MCLK) disable iff (!RST_N)
        r.state == SLT_HOLD |-> LAMP == SLT_LAMP_FULL)
        else $error("lamp not full during hold");
    // (R2) no exit between ticks
    AST_HOLD_STAY: assert property ( // (R2)
        @(posedge MCLK) disable iff (!RST_N)
        (r.state == SLT_HOLD && !tick) |=> r.state == SLT_HOLD)
        else $error("hold left between second ticks");
    // (R3) dim at hold end
    AST_HOLD_END: assert property ( // (R3)
        @(posedge MCLK) disable iff (!RST_N)
        (r.state == SLT_HOLD && tick && !btn &&
         hold_done(r.secs, hold_lim))
        |=> LAMP == SLT_LAMP_HALF)
        else $error("hold end did not dim lamp");
    // (R3) half during warning
    AST_WARN_HALF: assert property ( // (R3)
        @(posedge MCLK) disable iff (!RST_N)
        r.state == SLT_WARN |-> LAMP == SLT_LAMP_HALF)
        else $error("lamp not half during warning");
    // (R4) off after warning
    AST_WARN_END: assert property ( // (R4)
        @(posedge MCLK) disable iff (!RST_N)
        (r.state == SLT_WARN && !btn && tick &&
         r.secs == TIME_W'(WARN_S - 1))
        |=> LAMP == SLT_LAMP_OFF && r.state == SLT_IDLE)
        else $error("warning end did not switch lamp off");
    // (R4) no early switch-off
    AST_NO_EARLY_OFF: assert property ( // (R4)
        @(posedge MCLK) disable iff (!RST_N)
        (r.state == SLT_WARN && r.secs < TIME_W'(WARN_S - 1))
        |=> LAMP != SLT_LAMP_OFF)
        else $error("lamp off before warning elapsed");
    // (R4) warning kept between ticks
    AST_WARN_STAY: assert property ( // (R4)
        @(posedge MCLK) disable iff (!RST_N)
        (r.state == SLT_WARN && !tick && !btn) |=> r.state == SLT_WARN)
        else $error("warning left between second ticks");
    // (R4) idle means dark
    AST_IDLE_DARK: assert property ( // (R4)
        @(posedge MCLK) disable iff (!RST_N)
        r.state == SLT_IDLE |-> LAMP == SLT_LAMP_OFF)
        else $error("lamp lit while idle");
    // (R5) press in warning
    AST_WARN_PRESS: assert property ( // (R5)
        @(posedge MCLK) disable iff (!RST_N)
        (r.state == SLT_WARN) ##0 s_press |=> LAMP == SLT_LAMP_FULL)
        else $error("press in warning did not restore full");
    // (R6) stuck button goes dark
    AST_LOCK_ENTER: assert property ( // (R6)
        @(posedge MCLK) disable iff (!RST_N)
        s_stuck_expiry |=> LAMP == SLT_LAMP_OFF && r.state == SLT_LOCK)
        else $error("stuck button kept lamp on past hold");
    // (R6) dark while locked
    AST_LOCK_OFF: assert property ( // (R6)
        @(posedge MCLK) disable iff (!RST_N)
        r.state == SLT_LOCK |-> LAMP == SLT_LAMP_OFF)
        else $error("lamp on while locked");
    // (R7) lock kept while held
    AST_LOCK_HOLD: assert property ( // (R7)
        @(posedge MCLK) disable iff (!RST_N)
        (r.state == SLT_LOCK && btn) |=> r.state == SLT_LOCK)
        else $error("lock left while button still held");
    // (R7) release rearms
    AST_LOCK_EXIT: assert property ( // (R7)
        @(posedge MCLK) disable iff (!RST_N)
        s_lock_release |=> r.state == SLT_IDLE && LAMP == SLT_LAMP_OFF)
        else $error("release did not rearm after lock");
    // (R8) held button retriggers
    AST_RETRIG: assert property ( // (R8)
        @(posedge MCLK) disable iff (!RST_N)
        (r.state == SLT_HOLD && btn && !ANTI_LOCK) |=> r.secs == TIME_RST)
        else $error("held button did not retrigger");
    // (R8) no lock without option
    AST_NO_LOCK: assert property ( // (R8)
        @(posedge MCLK) disable iff (!RST_N)
        (r.state == SLT_HOLD && !ANTI_LOCK) |=> r.state != SLT_LOCK)
        else $error("lock entered with anti-lock off");
endmodule
`default_nettype wire

/* verification/slt_partner.sv */
// Pushbutton and dimmable lamp load model for the light timer bench.
// Assumes the bench requests button levels; contacts move after MCLK rises.
`default_nettype none
module slt_partner
    import slt_pkg::*;
(
    input wire logic clk,
    input wire slt_lamp_t lamp,
    output logic btn,
    output logic bad
);
    timeunit 1ns;
    timeprecision 1ps;
    logic want = 1'b0;
    logic odd = 1'b0;
    // Contact follows the request one edge later; released button reads low
    always @(posedge clk) begin
        btn <= want;
    end
    // A dimmer load has no meaning for the unused drive code; kept sticky
    // so a single bad cycle any time before the check in t_lock is still reported
    always @(posedge clk) begin
        odd <= odd | (lamp === slt_lamp_t'(2'h3));
    end
    assign bad = odd;
    task automatic set_btn(input logic v);
        want = v;
    endtask
endmodule
`default_nettype wire

/* verification/testbench.sv */
// Self-checking bench for the staircase light timer top level.
// Assumes a shortened second (10 cycles) and the button model in slt_partner.
`default_nettype none
module testbench;
    import slt_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    localparam longint SC = 10;
    logic mclk = 1'b0;
    logic rst_n = 1'b0;
    logic anti = 1'b0;
    logic [TIME_W-1:0] hold = 10'h01E;
    logic btn;
    logic bad;
    slt_lamp_t lamp;
    int n_fail = 0;
    int samples_checked = 0;
    int cyc = 0;
    int n;
    initial forever #2 mclk = ~mclk;
    slt_top #(.SEC_CYCLES(SC)) DUT (.MCLK(mclk), .RST_N(rst_n), .BTN(btn),
        .ANTI_LOCK(anti), .HOLD_SEC(hold), .LAMP(lamp));
    slt_partner pm (.clk(mclk), .lamp(lamp), .btn(btn), .bad(bad));
    task automatic check(input string what, input logic [15:0] seen,
        input logic [15:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            n_fail++;
            $display("unexpected %s: expected %h seen %h", what, exp, seen);
        end
    endtask
    // Bounded wait, sampled one ns after the edge so updates have landed
    task automatic wait_lamp(input slt_lamp_t v, input int lim);
        n = 0;
        while (lamp !== v && n < lim) begin
            @(posedge mclk);
            #1;
            n++;
        end
    endtask
    // An s-second span is s-1..s ticks plus sync delay; allow a margin
    task automatic span(input string what, input int s);
        check(what, 16'(n inside {[s * SC - 15 : s * SC + 5]}), 16'h0001);
    endtask
    task automatic do_reset(input logic a, input logic [TIME_W-1:0] h);
        pm.set_btn(1'b0);
        @(posedge mclk);
        rst_n <= 1'b0;
        anti <= a;
        hold <= h;
        repeat (2) @(posedge mclk);
        rst_n <= 1'b1;
        repeat (4) @(posedge mclk);
        #1;
        check("lamp after reset", 16'(lamp), 16'(SLT_LAMP_OFF));
    endtask
    task automatic light_up(input string what);
        pm.set_btn(1'b1);
        wait_lamp(SLT_LAMP_FULL, 8);
        check(what, 16'(n), 16'h0004); // press to full
    endtask
    task automatic t_cycle;
        do_reset(1'b0, 10'h3FF);
        light_up("idle press latency");
        pm.set_btn(1'b0);
        wait_lamp(SLT_LAMP_HALF, 6400);
        span("hold clamped to maximum", 600); // full for hold
        wait_lamp(SLT_LAMP_OFF, 400);
        span("warning length", 30); // half then off
        $display("test cycle done");
    endtask
    task automatic t_warn;
        do_reset(1'b0, 10'h005);
        light_up("first press");
        pm.set_btn(1'b0);
        wait_lamp(SLT_LAMP_HALF, 400);
        span("hold clamped to minimum", 30); // short setting clamped
        repeat (50) @(posedge mclk);
        #1;
        light_up("warning press latency"); // back to full
        pm.set_btn(1'b0);
        wait_lamp(SLT_LAMP_HALF, 400);
        span("new hold length", 30); // fresh hold period
        $display("test warn done");
    endtask
    task automatic t_lock;
        do_reset(1'b1, 10'h028);
        light_up("locked press latency");
        wait_lamp(SLT_LAMP_OFF, 500);
        span("anti lock shutoff", 40); // off after hold
        repeat (200) @(posedge mclk);
        #1;
        check("stuck input ignored", 16'(lamp), 16'(SLT_LAMP_OFF));
        pm.set_btn(1'b0);
        repeat (10) @(posedge mclk);
        #1;
        check("release stays off", 16'(lamp), 16'(SLT_LAMP_OFF));
        light_up("relight after release"); // new press works
        check("load code legal", 16'(bad), 16'h0000);
        $display("test lock done");
    endtask
    task automatic t_noloc;
        do_reset(1'b0, 10'h01E);
        light_up("held press latency");
        repeat (600) @(posedge mclk);
        #1;
        check("held retriggers", 16'(lamp), 16'(SLT_LAMP_FULL));
        pm.set_btn(1'b0);
        wait_lamp(SLT_LAMP_HALF, 400);
        span("hold after release", 30);
        $display("test no lock done");
    endtask
    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    // Whole run is about 9000 cycles, most of it the 600 s hold
    always @(posedge mclk) begin
        cyc++;
        if (cyc == 20000) begin
            n_fail++;
            report_and_stop();
        end
    end
    initial begin
        repeat (2) @(posedge mclk);
        rst_n <= 1'b1;
        t_cycle();
        t_warn();
        t_lock();
        t_noloc();
        report_and_stop();
    end
endmodule
`default_nettype wire
